//--- logic/lmem_pkg.sv
// Constants and types for the local memory strobe controller.
// Assumes a single 200 MHz clock domain.
package lmem_pkg;
  localparam int unsigned num_banks = 6;
  localparam int unsigned addr_width = 21;
  localparam logic [5:0] cs_idle = 6'h3f;
  localparam logic [3:0] we_idle = 4'hf;
  localparam logic [1:0] width_32 = 2'h0;
  localparam logic [1:0] width_16 = 2'h1;
  localparam logic [1:0] width_8 = 2'h2;
  localparam logic [1:0] sub_block_mask = 2'h3;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_access = 2'b01,
    st_finish = 2'b11
  } state_t;
endpackage

//--- logic/lmem_strobes.sv
// Local memory bus strobe generator: chip selects, output enable,
// per-lane write strobes and word address stepping.
// Assumes requests come from logic on the same clock.
// Word count, bank, width and lane enables are sampled with the request.
`timescale 1ns/1ps
module lmem_strobes #(
  parameter int unsigned aw = lmem_pkg::addr_width
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [2:0] req_bank,
  input wire logic [1:0] req_width,
  input wire logic req_sub_block,
  input wire logic [aw-1:0] req_word_addr,
  input wire logic [1:0] req_byte_addr,
  input wire logic [3:0] req_byte_en,
  input wire logic [3:0] req_words,
  input wire logic word_done,
  output logic busy,
  output logic [aw-1:0] mem_addr,
  output logic [5:0] mem_cs_n,
  output logic mem_oe_n,
  output logic [3:0] mem_we_n
);
  lmem_pkg::state_t state, next_state;
  // Captured request
  logic [aw-1:0] base, next_base;
  logic [3:0] offset, next_offset;
  logic [3:0] left, next_left;
  logic write, next_write;
  logic sub_block, next_sub_block;
  logic [2:0] bank, next_bank;
  logic [1:0] width, next_width;
  logic [1:0] byte_addr, next_byte_addr;
  logic [3:0] byte_en, next_byte_en;
  logic [aw-1:0] next_mem_addr;
  logic [5:0] next_mem_cs_n;
  logic next_mem_oe_n;
  logic [3:0] next_mem_we_n;
  logic [3:0] lanes;
  logic active;
  logic [5:0] cs_hit;
  logic [3:0] lane_we_n;

  // Handshake outputs decode the state directly
  assign req_ready = (state == lmem_pkg::st_idle);
  assign busy = (state != lmem_pkg::st_idle);

  // Sequencer and request capture. A word count of zero runs one word,
  // and a bank code past the last bank falls back to bank 0 so that
  // exactly one chip select is ever driven.
  always_comb begin
    next_state = state;
    next_base = base;
    next_offset = offset;
    next_left = left;
    next_write = write;
    next_sub_block = sub_block;
    next_bank = bank;
    next_width = width;
    next_byte_addr = byte_addr;
    next_byte_en = byte_en;
    unique case (state)
      lmem_pkg::st_idle: begin
        if (req_valid) begin
          next_state = lmem_pkg::st_access;
          next_base = req_word_addr;
          next_offset = 4'h0;
          next_left = (req_words == 4'h0) ? 4'h1 : req_words;
          next_write = req_write;
          next_sub_block = req_sub_block;
          next_bank = (req_bank < 3'(lmem_pkg::num_banks)) ? req_bank : 3'h0;
          next_width = req_width;
          next_byte_addr = req_byte_addr;
          next_byte_en = req_byte_en;
        end
      end
      lmem_pkg::st_access: begin
        if (word_done) begin
          // Each finished word advances the order counter
          next_offset = offset + 4'h1;
          next_left = left - 4'h1;
          if (left == 4'h1) begin
            next_state = lmem_pkg::st_finish;
          end
        end
      end
      // One quiet cycle here, then at least one quiet idle cycle, between transfers
      lmem_pkg::st_finish: begin
        next_state = lmem_pkg::st_idle;
      end
      // Unused state code returns to idle
      default: begin
        next_state = lmem_pkg::st_idle;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= lmem_pkg::st_idle;
      base <= '0;
      offset <= 4'h0;
      left <= 4'h0;
      write <= 1'b0;
      sub_block <= 1'b0;
      bank <= 3'h0;
      width <= lmem_pkg::width_32;
      byte_addr <= 2'h0;
      byte_en <= 4'h0;
    end else begin
      state <= next_state;
      base <= next_base;
      offset <= next_offset;
      left <= next_left;
      write <= next_write;
      sub_block <= next_sub_block;
      bank <= next_bank;
      width <= next_width;
      byte_addr <= next_byte_addr;
      byte_en <= next_byte_en;
    end
  end

  // Pin registers. Every pin group is computed from the next state
  // so the pins move on the same edge as the sequencer and no request
  // input reaches a pin without passing a flip-flop.
  assign active = (next_state == lmem_pkg::st_access);
  assign lanes = next_byte_en;

  // Address group
  always_comb begin
    if (next_sub_block) begin
      // Sub-block order stays inside the aligned four-word block
      next_mem_addr = {next_base[aw-1:2],
        next_base[1:0] ^ next_offset[1:0]};
    end else begin
      // Linear order may cross any block boundary
      next_mem_addr = next_base + aw'(next_offset);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_addr <= '0;
    end else begin
      mem_addr <= next_mem_addr;
    end
  end

  // Select group: one chip select per bank
  for (genvar b = 0; b < lmem_pkg::num_banks; b++) begin : g_cs
    assign cs_hit[b] = active && (next_bank == 3'(b));
  end

  always_comb begin
    next_mem_cs_n = ~cs_hit;
    // Reads only, so the bank never fights a write on the data bus
    next_mem_oe_n = ~(active && !next_write);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_cs_n <= lmem_pkg::cs_idle;
      mem_oe_n <= 1'b1;
    end else begin
      mem_cs_n <= next_mem_cs_n;
      mem_oe_n <= next_mem_oe_n;
    end
  end

  // Strobe group. Per-lane enables serve full-width ports; narrow
  // ports reuse the same lines as enables and address bits.
  for (genvar l = 0; l < 4; l++) begin : g_lane
    assign lane_we_n[l] = ~(next_write && lanes[l]);
  end

  always_comb begin
    next_mem_we_n = lmem_pkg::we_idle;
    if (active) begin
      unique case (next_width)
        lmem_pkg::width_16: begin
          // Two byte enables; line 1 parked low, line 2 high
          next_mem_we_n[3] = ~(next_write && (lanes[3] || lanes[1]));
          next_mem_we_n[2] = 1'b1;
          next_mem_we_n[1] = 1'b0;
          next_mem_we_n[0] = ~(next_write && (lanes[2] || lanes[0]));
        end
        lmem_pkg::width_8: begin
          // One byte enable; lines 2 and 1 carry the byte address
          next_mem_we_n[3] = 1'b1;
          next_mem_we_n[2] = next_byte_addr[1];
          next_mem_we_n[1] = next_byte_addr[0];
          next_mem_we_n[0] = ~(next_write && (|lanes));
        end
        default: begin
          // Full width and the unused width code strobe per lane
          next_mem_we_n = lane_we_n;
        end
      endcase
    end
  end

  // Strobes park high in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_we_n <= lmem_pkg::we_idle;
    end else begin
      mem_we_n <= next_mem_we_n;
    end
  end
endmodule

//--- tb/lmem_strobes_asserts.sv
// Checker on the strobe generator ports; bound from the bench.
`timescale 1ns/1ps
module lmem_strobes_asserts #(parameter int unsigned aw = 21) (
  input logic clk, rst, req_valid, req_ready, req_write, req_sub_block,
  input logic word_done, busy, mem_oe_n,
  input logic [2:0] req_bank,
  input logic [1:0] req_width, req_byte_addr,
  input logic [aw-1:0] req_word_addr, mem_addr,
  input logic [3:0] req_byte_en, req_words, mem_we_n,
  input logic [5:0] mem_cs_n);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic go;
  assign go = req_valid && req_ready;
  a_cs_bank: assert property (go && req_bank < 6 |=>
    mem_cs_n == (6'h3f ^ 6'h01 << $past(req_bank))) else $error("cs");
  a_oe_read: assert property (go |=> mem_oe_n == $past(req_write))
    else $error("oe");
  a_we_half: assert property (go && req_width == 1 |=>
    mem_we_n[2:1] == 2'h2) else $error("we16");
  a_we_byte: assert property (go && req_width == 2 |=>
    mem_we_n[3:1] == {1'b1, $past(req_byte_addr)}) else $error("we8");
  a_we_lanes: assert property (go && req_write && req_width == 0 |=>
    mem_we_n == ~$past(req_byte_en)) else $error("we32");
  a_addr_step: assert property (word_done && !req_sub_block &&
    !(&mem_cs_n) |=> &mem_cs_n || mem_addr == $past(mem_addr) + 1'b1)
    else $error("addr");
endmodule

//--- tb/lmem_mem_model.sv
// Memory model: ends each word lat+1 cycles into the access.
`timescale 1ns/1ps
module lmem_mem_model (input logic clk, rst, input logic [5:0] mem_cs_n,
  input logic [3:0] lat, output logic word_done);
  logic [3:0] cnt;
  always_ff @(posedge clk or posedge rst)
    if (rst) begin
      cnt <= 4'h0;
      word_done <= 1'b0;
    end else if (mem_cs_n == 6'h3f || word_done) begin
      cnt <= 4'h0;
      word_done <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
      word_done <= cnt == lat;
    end
endmodule

//--- tb/lmem_strobes_tb.sv
// Bench for the strobe generator with a pacing memory model.
`timescale 1ns/1ps
module lmem_strobes_tb;
  logic clk = 0, rst = 1, req_valid = 0, req_write = 0, req_sub_block = 0;
  logic req_ready, busy, mem_oe_n, word_done;
  logic [2:0] req_bank = 0;
  logic [1:0] req_width = 0, req_byte_addr = 0;
  logic [3:0] req_byte_en = 0, req_words = 0, lat = 0, mem_we_n, ew;
  logic [20:0] req_word_addr = 0, mem_addr;
  logic [5:0] mem_cs_n;
  int err_count = 0, checked = 0;
  always #2.5 clk = ~clk;
  lmem_strobes dut(.*);
  lmem_mem_model model(.*);
  task cmp(string n, logic [20:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task xfer(logic w, logic [2:0] b, logic [1:0] wd, logic s, logic [3:0] n, l);
    {req_write, req_bank, req_width, req_sub_block, req_words, lat} =
      {w, b, wd, s, n, l};
    case (wd)
      1: ew = {~(w & (req_byte_en[3] | req_byte_en[1])), 2'b10,
        ~(w & (req_byte_en[2] | req_byte_en[0]))};
      2: ew = {1'b1, req_byte_addr, ~(w & |req_byte_en)};
      default: ew = w ? ~req_byte_en : 4'hf;
    endcase
    req_valid = 1;
    @(posedge clk) #1 req_valid = 0;
    for (int i = 0; i < (n ? n : 1); i++) begin
      cmp("addr", s ? {req_word_addr[20:2], req_word_addr[1:0] ^ i[1:0]}
        : req_word_addr + i, mem_addr);
      cmp("cs", 6'h3f ^ 6'h01 << (b > 5 ? 0 : b), mem_cs_n);
      cmp("oe", w, mem_oe_n);
      cmp("we", ew, mem_we_n);
      cmp("busy", 1, busy);
      while (!word_done) @(posedge clk) #1;
      @(posedge clk) #1;
    end
    cmp("idle", 6'h3f, mem_cs_n);
    cmp("oe idle", 1, mem_oe_n);
    cmp("we idle", 4'hf, mem_we_n);
    cmp("ready", 0, req_ready);
    @(posedge clk) #1 cmp("ready", 1, req_ready);
    cmp("busy", 0, busy);
  endtask
  task t_reset;
    req_valid = 1;
    req_words = 4'h4;
    @(posedge clk) #1 req_valid = 0;
    cmp("busy", 1, busy);
    rst = 1;
    #1 cmp("cs rst", 6'h3f, mem_cs_n);
    cmp("we rst", 4'hf, mem_we_n);
    cmp("oe rst", 1, mem_oe_n);
    cmp("busy rst", 0, busy);
    @(posedge clk) #1 rst = 0;
    cmp("ready rst", 1, req_ready);
  endtask
  task t_wide;
    req_word_addr = 21'h1f_fffe;
    req_byte_en = 4'h5;
    xfer(1, 5, 0, 0, 4, 0);
  endtask
  task t_half;
    req_byte_en = 4'h2;
    xfer(1, 2, 1, 0, 2, 3);
    xfer(0, 3, 1, 0, 1, 0);
  endtask
  task t_byte;
    req_word_addr = 21'h0_0006;
    req_byte_addr = 2'h2;
    xfer(1, 1, 2, 1, 4, 1);
    xfer(0, 4, 2, 1, 0, 2);
  endtask
  task t_banks;
    for (int b = 0; b < 8; b++) xfer(0, b, 0, 0, 1, 0);
    xfer(1, 0, 3, 0, 1, 0);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 0;
    t_wide;
    t_half;
    t_reset;
    t_byte;
    t_banks;
    end_of_test;
  end
  initial begin
    #20000 err_count++;
    end_of_test;
  end
endmodule
bind lmem_strobes lmem_strobes_asserts #(.aw(aw)) chk(.*);
